// ==== rtl/dac_reset_clear_crc_regbank.sv ====
// Purpose: serial register bank, reset/clear handling, frame check and trim math
// Assumes: pins are asynchronous to clock; sclk well below clock/8
// Notes: open-drain and tristate pins are split into value and active-low enable
`timescale 1ns/1ps
`default_nettype none
module dac_reset_clear_crc_regbank #(
   parameter logic [2:0] PART_ID = 3'h5 // arbitrary value
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   // serial link pins
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n,
   // control pins
   input wire logic reset_pin_n,
   input wire logic output_wipe_input,
   input wire logic load_latch_strobe_n,
   output logic alarm_out,
   output logic alarm_oe_n,
   // converter side
   output logic [15:0] channel_code [dac_core_pkg::NUM_CH],
   output logic ref_enable,
   output logic power_off_condition,
   output logic watchdog_kick
);
   localparam int NC = dac_core_pkg::NUM_CH;

   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 31; i >= 0; i--)
      begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? dac_core_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   function automatic logic [1:0] first_sel(input logic [3:0] s);
      logic [1:0] r;
      r = 2'd0;
      for (int i = 3; i >= 0; i--)
      begin
         if (s[i])
         begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] trim(input logic [15:0] code, input logic [15:0] g, input logic [15:0] o);
      logic [32:0] prod;
      logic signed [18:0] sum;
      prod = {17'h0, code} * {16'h0, {1'b0, g} + dac_core_pkg::GAIN_BIAS};
      sum = signed'({2'b00, prod[32:16]}) + signed'({{3{o[15]}}, o});
      if (sum < 0)
      begin
         return dac_core_pkg::ZEROSCALE;
      end
      else if (sum > signed'(dac_core_pkg::CODE_TOP))
      begin
         return 16'hFFFF;
      end
      return sum[15:0];
   endfunction

   // pin synchronisers
   logic [5:0] pins_in, s1_q, s2_q, s3_q, f_q, fp_q;
   assign pins_in = {load_latch_strobe_n, output_wipe_input, reset_pin_n, serial_in, sync_n, sclk};
   for (genvar p = 0; p < dac_core_pkg::NUM_PINS; p++)
   begin : g_pin
      always_ff @(posedge clock or posedge reset)
      begin
         if (reset)
         begin
            s1_q[p] <= dac_core_pkg::PIN_IDLE[p];
            s2_q[p] <= dac_core_pkg::PIN_IDLE[p];
            s3_q[p] <= dac_core_pkg::PIN_IDLE[p];
            f_q[p] <= dac_core_pkg::PIN_IDLE[p];
            fp_q[p] <= dac_core_pkg::PIN_IDLE[p];
         end
         else if (clock_enable)
         begin
            s1_q[p] <= pins_in[p];
            s2_q[p] <= s1_q[p];
            s3_q[p] <= s2_q[p];
            if (s2_q[p] == s3_q[p])
            begin
               f_q[p] <= s3_q[p];
            end
            fp_q[p] <= f_q[p];
         end
      end
   end

   logic sclk_fall, sclk_rise, sync_fall, sync_rise, load_fall, hw_rst, wipe;
   assign sclk_fall = fp_q[dac_core_pkg::PIN_SCLK] & ~f_q[dac_core_pkg::PIN_SCLK];
   assign sclk_rise = ~fp_q[dac_core_pkg::PIN_SCLK] & f_q[dac_core_pkg::PIN_SCLK];
   assign sync_fall = fp_q[dac_core_pkg::PIN_SYNC] & ~f_q[dac_core_pkg::PIN_SYNC];
   assign sync_rise = ~fp_q[dac_core_pkg::PIN_SYNC] & f_q[dac_core_pkg::PIN_SYNC];
   assign load_fall = fp_q[dac_core_pkg::PIN_LOAD] & ~f_q[dac_core_pkg::PIN_LOAD];
   assign hw_rst = ~f_q[dac_core_pkg::PIN_RSTN];
   assign wipe = f_q[dac_core_pkg::PIN_WIPE];

   // global registers
   logic [15:0] rcfg_q, sel_q, csel_q, fmask_q, act_q;
   logic soft_rst_q, poc_q, cre_q, clst_q, kick_q, swclr_q, regs_clear;
   logic frame_check_enable, pass_through_mode;
   assign regs_clear = hw_rst | soft_rst_q;
   assign frame_check_enable = sel_q[dac_core_pkg::FRAME_CHECK_ENABLE_BIT];
   assign pass_through_mode = rcfg_q[dac_core_pkg::TRN_BIT];

   // frame receive
   logic [31:0] shift_q, load_word;
   logic [5:0] count_q, frame_len;
   logic active_q, sdo_q, commit, crc_ok, wr_en, rd_req, rd_pending_q;
   logic [23:0] frame, rd_frame;
   logic [6:0] addr, rd_addr_q;
   logic [15:0] wdata, rd_data;
   assign frame_len = frame_check_enable ? dac_core_pkg::FRAME_LONG : dac_core_pkg::FRAME_SHORT;
   assign frame = frame_check_enable ? shift_q[31:8] : shift_q[23:0];
   assign addr = frame[22:16];
   assign wdata = frame[15:0];
   assign crc_ok = ~frame_check_enable | (crc8(shift_q) == 8'h00);
   assign commit = sync_rise & active_q & ~pass_through_mode & ~hw_rst & (count_q >= frame_len);
   assign wr_en = commit & ~frame[dac_core_pkg::RW_BIT] & crc_ok;
   assign rd_req = commit & frame[dac_core_pkg::RW_BIT] & crc_ok;
   assign rd_frame = {1'b0, rd_addr_q, rd_pending_q ? rd_data : 16'h0000};
   assign load_word = frame_check_enable ? {rd_frame, crc8({8'h00, rd_frame})} : {8'h00, rd_frame};

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         shift_q <= 32'h0000_0000;
         count_q <= 6'h00;
         active_q <= 1'b0;
         sdo_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         if (hw_rst)
         begin
            active_q <= 1'b0;
            count_q <= 6'h00;
         end
         else if (sync_fall)
         begin
            active_q <= 1'b1;
            count_q <= 6'h00;
            shift_q <= load_word;
            sdo_q <= frame_check_enable ? load_word[31] : load_word[23];
         end
         else if (sync_rise)
         begin
            active_q <= 1'b0;
         end
         else if (active_q && sclk_fall)
         begin
            shift_q <= {shift_q[30:0], f_q[dac_core_pkg::PIN_SIN]};
            if (count_q != dac_core_pkg::COUNT_MAX)
            begin
               count_q <= count_q + 6'd1;
            end
         end
         else if (active_q && sclk_rise)
         begin
            // out bit changes on rise so the next device samples it on the fall
            sdo_q <= frame_check_enable ? shift_q[31] : shift_q[23];
         end
         if (pass_through_mode && active_q)
         begin
            sdo_q <= f_q[dac_core_pkg::PIN_SIN];
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rd_pending_q <= 1'b0;
         rd_addr_q <= 7'h00;
      end
      else if (clock_enable)
      begin
         if (regs_clear)
         begin
            rd_pending_q <= 1'b0;
         end
         else if (rd_req)
         begin
            rd_pending_q <= 1'b1;
            rd_addr_q <= addr;
         end
         else if (sync_fall)
         begin
            rd_pending_q <= 1'b0;
         end
      end
   end

   assign serial_out = sdo_q;
   assign serial_out_oe_n = ~(active_q & ~hw_rst & ~sel_q[dac_core_pkg::DSDO_BIT]);

   // global register writes
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rcfg_q <= 16'h0000;
         sel_q <= 16'h0000;
         csel_q <= 16'h0000;
         fmask_q <= 16'h0000;
         act_q <= 16'h0000;
         clst_q <= 1'b1;
      end
      else if (clock_enable)
      begin
         if (regs_clear)
         begin
            rcfg_q <= 16'h0000;
            sel_q <= 16'h0000;
            csel_q <= 16'h0000;
            fmask_q <= 16'h0000;
            act_q <= 16'h0000;
            clst_q <= 1'b1;
         end
         else if (wr_en)
         begin
            case (addr)
               dac_core_pkg::ADDR_RCFG: rcfg_q <= wdata & dac_core_pkg::RCFG_MASK;
               dac_core_pkg::ADDR_SEL: sel_q <= wdata & dac_core_pkg::SEL_MASK;
               dac_core_pkg::ADDR_CSEL: csel_q <= wdata & dac_core_pkg::CSEL_MASK;
               dac_core_pkg::ADDR_MASK: fmask_q <= wdata & dac_core_pkg::FMASK_MASK;
               dac_core_pkg::ADDR_ACT: act_q <= wdata & dac_core_pkg::ACT_MASK;
               dac_core_pkg::ADDR_STAT: clst_q <= clst_q & ~wdata[dac_core_pkg::CLST_BIT];
               default: clst_q <= clst_q;
            endcase
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         soft_rst_q <= 1'b0;
         swclr_q <= 1'b0;
         kick_q <= 1'b0;
         poc_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         soft_rst_q <= wr_en & ~soft_rst_q & (addr == dac_core_pkg::ADDR_RST) & wdata[dac_core_pkg::RST_BIT];
         swclr_q <= wr_en & (addr == dac_core_pkg::ADDR_RCFG) & wdata[dac_core_pkg::SWCLR_BIT];
         kick_q <= wr_en & (addr == dac_core_pkg::ADDR_WDOG) & wdata[dac_core_pkg::KICK_BIT];
         // power-off condition survives both resets; power-up or an RCFG write with the bit low clears it
         if (wr_en && addr == dac_core_pkg::ADDR_RCFG)
         begin
            poc_q <= wdata[dac_core_pkg::POC_BIT];
         end
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cre_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         if (regs_clear)
         begin
            cre_q <= 1'b0;
         end
         else if (commit && !crc_ok)
         begin
            cre_q <= 1'b1;
         end
         else if (!frame_check_enable)
         begin
            cre_q <= 1'b0;
         end
      end
   end

   assign alarm_out = 1'b0;
   assign alarm_oe_n = ~(cre_q & ~fmask_q[dac_core_pkg::MCRE_BIT]);
   assign ref_enable = rcfg_q[dac_core_pkg::REFEN_BIT];
   assign power_off_condition = poc_q;
   assign watchdog_kick = kick_q;

   // per-channel state
   logic [15:0] cfg_q [NC], data_q [NC], ccfg_q [NC], gain_q [NC], ofs_q [NC], acode_q [NC], latch_q [NC];
   logic [NC-1:0] cal_q, wiped_q, wipe_now;
   logic [3:0] ch_sel, cv_sel;
   logic load_async, load_latch_strobe_load;
   assign ch_sel = sel_q[dac_core_pkg::CH_LSB +: 4];
   assign cv_sel = csel_q[3:0];
   assign load_async = ~f_q[dac_core_pkg::PIN_LOAD];
   assign load_latch_strobe_load = load_fall & ~wipe;

   for (genvar i = 0; i < NC; i++)
   begin : g_ch
      logic wr_ch, wr_cv, permit, new_data;
      assign wr_ch = wr_en & ch_sel[i];
      assign wr_cv = wr_en & cv_sel[i];
      assign permit = rcfg_q[dac_core_pkg::PERMIT_LSB + i];
      assign new_data = wr_ch & (addr == dac_core_pkg::ADDR_DATA);
      assign wipe_now[i] = wiped_q[i] | (wipe & permit);

      always_ff @(posedge clock or posedge reset)
      begin
         if (reset)
         begin
            cfg_q[i] <= 16'h0000;
            data_q[i] <= 16'h0000;
            ccfg_q[i] <= 16'h0000;
            cal_q[i] <= 1'b0;
            gain_q[i] <= dac_core_pkg::GAIN_RESET;
            ofs_q[i] <= 16'h0000;
            acode_q[i] <= 16'h0000;
         end
         else if (clock_enable)
         begin
            if (regs_clear)
            begin
               cfg_q[i] <= 16'h0000;
               data_q[i] <= 16'h0000;
               ccfg_q[i] <= 16'h0000;
               cal_q[i] <= 1'b0;
               gain_q[i] <= dac_core_pkg::GAIN_RESET;
               ofs_q[i] <= 16'h0000;
               acode_q[i] <= 16'h0000;
            end
            else
            begin
               if (wr_ch && addr == dac_core_pkg::ADDR_CFG) cfg_q[i] <= wdata;
               if (new_data) data_q[i] <= wdata;
               if (wr_cv && addr == dac_core_pkg::ADDR_CCFG) ccfg_q[i] <= wdata & dac_core_pkg::CCFG_MASK;
               if (wr_ch && addr == dac_core_pkg::ADDR_CAL) cal_q[i] <= wdata[dac_core_pkg::TRIM_ENABLE_BIT];
               if (wr_ch && addr == dac_core_pkg::ADDR_GAIN) gain_q[i] <= wdata;
               if (wr_ch && addr == dac_core_pkg::ADDR_OFS) ofs_q[i] <= wdata;
               if (wr_ch && addr == dac_core_pkg::ADDR_ACODE) acode_q[i] <= wdata & dac_core_pkg::ACODE_MASK;
            end
         end
      end

      always_ff @(posedge clock or posedge reset)
      begin
         if (reset)
         begin
            latch_q[i] <= 16'h0000;
            wiped_q[i] <= 1'b0;
            channel_code[i] <= 16'h0000;
         end
         else if (clock_enable)
         begin
            if (regs_clear)
            begin
               latch_q[i] <= 16'h0000;
               wiped_q[i] <= 1'b0;
               channel_code[i] <= 16'h0000;
            end
            else
            begin
               if (new_data && load_async)
               begin
                  latch_q[i] <= wdata;
               end
               else if (load_latch_strobe_load)
               begin
                  latch_q[i] <= data_q[i];
               end
               // set wins, so a held wipe keeps the channel cleared
               if ((wipe || swclr_q) && permit)
               begin
                  wiped_q[i] <= 1'b1;
               end
               else if (new_data)
               begin
                  wiped_q[i] <= 1'b0;
               end
               // wipe bypasses any slewing: the code jumps in one cycle
               if (wipe_now[i] || (swclr_q && permit))
               begin
                  channel_code[i] <= sel_q[dac_core_pkg::CLSL_LSB + i] ? dac_core_pkg::MIDSCALE
                                                                       : dac_core_pkg::ZEROSCALE;
               end
               else
               begin
                  channel_code[i] <= cal_q[i] ? trim(latch_q[i], gain_q[i], ofs_q[i]) : latch_q[i];
               end
            end
         end
      end
   end

   // readback mux
   logic [1:0] rc, rv;
   assign rc = first_sel(ch_sel);
   assign rv = first_sel(cv_sel);
   always_comb
   begin
      rd_data = 16'h0000;
      case (rd_addr_q)
         dac_core_pkg::ADDR_RCFG: rd_data = rcfg_q | (16'(poc_q) << dac_core_pkg::POC_BIT);
         dac_core_pkg::ADDR_SEL: rd_data = sel_q;
         dac_core_pkg::ADDR_CFG: rd_data = cfg_q[rc];
         dac_core_pkg::ADDR_DATA: rd_data = data_q[rc];
         dac_core_pkg::ADDR_CSEL: rd_data = csel_q;
         dac_core_pkg::ADDR_CCFG: rd_data = ccfg_q[rv];
         dac_core_pkg::ADDR_CAL: rd_data = 16'(cal_q[rc]);
         dac_core_pkg::ADDR_GAIN: rd_data = gain_q[rc];
         dac_core_pkg::ADDR_OFS: rd_data = ofs_q[rc];
         dac_core_pkg::ADDR_STAT:
         begin
            rd_data[dac_core_pkg::CLST_BIT] = clst_q;
            rd_data[dac_core_pkg::UTGL_BIT] = rcfg_q[dac_core_pkg::UBT_BIT];
            rd_data[dac_core_pkg::CRE_BIT] = cre_q;
         end
         dac_core_pkg::ADDR_MASK: rd_data = fmask_q;
         dac_core_pkg::ADDR_ACT: rd_data = act_q;
         dac_core_pkg::ADDR_ACODE: rd_data = acode_q[rc];
         dac_core_pkg::ADDR_ID: rd_data = {13'h0000, PART_ID};
         default: rd_data = 16'h0000;
      endcase
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence bad_frame_s;
      commit && frame_check_enable && !crc_ok;
   endsequence
   sequence wipe_ch0_s;
      wipe && rcfg_q[dac_core_pkg::PERMIT_LSB] && !regs_clear && clock_enable;
   endsequence
   bad_frame_flag_a: assert property (bad_frame_s ##0 clock_enable |=> cre_q ##0 !wr_en)
      else $error("bad frame did not set error flag");
   bad_frame_block_a: assert property (bad_frame_s |-> !wr_en && !rd_req)
      else $error("bad frame reached the registers");
   alarm_pin_low_a: assert property (cre_q && !fmask_q[dac_core_pkg::MCRE_BIT] |-> !alarm_oe_n)
      else $error("alarm not driven with error flag set");
   short_frame_drop_a: assert property (sync_rise && active_q && count_q < frame_len |-> !wr_en && !rd_req)
      else $error("short frame was accepted");
   soft_reset_clear_a: assert property (soft_rst_q && clock_enable |=> !soft_rst_q && sel_q == 16'h0000 && !cre_q)
      else $error("soft reset did not restore and self clear");
   pin_reset_hiz_a: assert property (hw_rst && clock_enable |=> serial_out_oe_n && gain_q[0] == dac_core_pkg::GAIN_RESET)
      else $error("pin reset left out driven or gain changed");
   wipe_output_a: assert property (wipe_ch0_s |=> channel_code[0] == (sel_q[dac_core_pkg::CLSL_LSB] ? 16'h8000 : 16'h0000))
      else $error("wipe did not force channel code");
   wipe_load_ignore_a: assert property (wipe |-> !load_latch_strobe_load)
      else $error("load strobe taken during wipe");
   trim_bypass_a: assert property (!cal_q[0] && !wipe_now[0] && !swclr_q && !regs_clear && clock_enable
                                   |=> channel_code[0] == $past(latch_q[0]))
      else $error("untrimmed channel code differs from latch");
   check_off_clear_a: assert property (!frame_check_enable && clock_enable |=> !cre_q)
      else $error("error flag kept with check disabled");
endmodule
`default_nettype wire

// ==== inc/dac_core_pkg.sv ====
// Purpose: shared constants for the quad output converter control core
// Assumes: 24-bit frames {rw, addr[6:0], data[15:0]}, optional 8-bit check byte
// Notes: one word per register, per-channel registers replicated four times
package dac_core_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_PINS = 6;
   localparam logic [5:0] FRAME_SHORT = 6'd24;
   localparam logic [5:0] FRAME_LONG = 6'd32;
   localparam logic [5:0] COUNT_MAX = 6'h3F;
   // pin order: 0 sclk, 1 sync_n, 2 serial_in, 3 reset_pin_n, 4 wipe, 5 load strobe
   localparam logic [5:0] PIN_IDLE = 6'h2A;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SYNC = 1;
   localparam int PIN_SIN = 2;
   localparam int PIN_RSTN = 3;
   localparam int PIN_WIPE = 4;
   localparam int PIN_LOAD = 5;
   localparam int RW_BIT = 23;
   localparam logic [6:0] ADDR_NOP = 7'h00;
   localparam logic [6:0] ADDR_RST = 7'h01;
   localparam logic [6:0] ADDR_RCFG = 7'h02;
   localparam logic [6:0] ADDR_SEL = 7'h03;
   localparam logic [6:0] ADDR_CFG = 7'h04;
   localparam logic [6:0] ADDR_DATA = 7'h05;
   localparam logic [6:0] ADDR_CSEL = 7'h06;
   localparam logic [6:0] ADDR_CCFG = 7'h07;
   localparam logic [6:0] ADDR_CAL = 7'h08;
   localparam logic [6:0] ADDR_GAIN = 7'h09;
   localparam logic [6:0] ADDR_OFS = 7'h0A;
   localparam logic [6:0] ADDR_STAT = 7'h0B;
   localparam logic [6:0] ADDR_MASK = 7'h0C;
   localparam logic [6:0] ADDR_ACT = 7'h0D;
   localparam logic [6:0] ADDR_ACODE = 7'h0E;
   localparam logic [6:0] ADDR_WDOG = 7'h10;
   localparam logic [6:0] ADDR_ID = 7'h11;
   localparam int RST_BIT = 0;
   localparam int UBT_BIT = 0;
   localparam int POC_BIT = 1;
   localparam int SWCLR_BIT = 2;
   localparam int TRN_BIT = 3;
   localparam int REFEN_BIT = 4;
   localparam int PERMIT_LSB = 9;
   localparam int CLSL_LSB = 9;
   localparam int CH_LSB = 5;
   localparam int DSDO_BIT = 4;
   localparam int FRAME_CHECK_ENABLE_BIT = 3;
   localparam int TRIM_ENABLE_BIT = 0;
   localparam int KICK_BIT = 0;
   localparam int CRE_BIT = 5;
   localparam int UTGL_BIT = 6;
   localparam int CLST_BIT = 12;
   localparam int MCRE_BIT = 5;
   localparam logic [15:0] RCFG_MASK = 16'h1E19;
   localparam logic [15:0] SEL_MASK = 16'h1FFF;
   localparam logic [15:0] CSEL_MASK = 16'h000F;
   localparam logic [15:0] CCFG_MASK = 16'h0FFF;
   localparam logic [15:0] FMASK_MASK = 16'h083F;
   localparam logic [15:0] ACT_MASK = 16'h00FF;
   localparam logic [15:0] ACODE_MASK = 16'hFE00;
   localparam logic [15:0] GAIN_RESET = 16'h8000;
   localparam logic [15:0] MIDSCALE = 16'h8000;
   localparam logic [15:0] ZEROSCALE = 16'h0000;
   localparam logic [16:0] GAIN_BIAS = 17'h08000;
   localparam logic [18:0] CODE_TOP = 19'h0FFFF;
   localparam logic [7:0] CRC_POLY = 8'h07;
endpackage

// ==== verification/spi_host_model.sv ====
// Purpose: host-side serial controller driving frames into the bank
// Assumes: data set before sclk rise, captured back 20 ns after the fall
// Notes: a released serial_out reads as the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // link pins
   output logic sclk,
   output logic sync_n,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   logic [31:0] rd;
   initial
   begin
      sclk = 1'b0;
      sync_n = 1'b1;
      serial_in = 1'b0;
      rd = 32'h0;
   end
   // n below the frame length models an aborted transfer
   task automatic xfer(input logic [31:0] w, input int n);
      sync_n = 1'b0;
      #48;
      // data moves and readback is taken 20 ns after each fall, clear of the
      // device's filtered edges, which lag the pins by up to 25 ns
      for (int i = n - 1; i >= 0; i--)
      begin
         #20;
         if (i != n - 1)
         begin
            rd = {rd[30:0], serial_out_oe_n ? ~rd[0] : serial_out};
         end
         serial_in = w[i];
         #4 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      #20 rd = {rd[30:0], serial_out_oe_n ? ~rd[0] : serial_out};
      #4 sync_n = 1'b1;
      serial_in = ~serial_in;
      #150;
   endtask
endmodule
`default_nettype wire

// ==== verification/dac_reset_clear_crc_regbank_test.sv ====
// Purpose: frame-level checks of reset, wipe, trim and frame check
// Assumes: 200 MHz clock, host model on the serial pins
// Notes: check off frames carry a padding byte in front
`timescale 1ns/1ps
`default_nettype none
`define check_eq(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module dac_reset_clear_crc_regbank_test;
   logic clock, reset, reset_pin_n, output_wipe_input, load_latch_strobe_n, chk;
   logic sclk, sync_n, serial_in, serial_out, serial_out_oe_n, alarm_out, alarm_oe_n;
   logic ref_enable, power_off_condition, watchdog_kick;
   logic [15:0] channel_code [dac_core_pkg::NUM_CH];
   logic [15:0] d;
   int n_errors = 0, samples_checked = 0, kicks = 0;
   spi_host_model u_spi_host_model (.sclk(sclk), .sync_n(sync_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
   // part id value is arbitrary
   dac_reset_clear_crc_regbank #(.PART_ID(3'h3)) u_dac_reset_clear_crc_regbank (.clock(clock), .reset(reset),
      .clock_enable(1'b1), .sclk(sclk), .sync_n(sync_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .reset_pin_n(reset_pin_n), .output_wipe_input(output_wipe_input),
      .load_latch_strobe_n(load_latch_strobe_n), .alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n),
      .channel_code(channel_code), .ref_enable(ref_enable), .power_off_condition(power_off_condition),
      .watchdog_kick(watchdog_kick));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) kicks <= kicks + int'(watchdog_kick === 1'b1);
   function automatic logic [7:0] crc8(input logic [23:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   task automatic send(input logic rw, input logic [6:0] a, input logic [15:0] v, input logic bad = 1'b0);
      logic [23:0] w;
      w = {rw, a, v};
      if (chk)
         u_spi_host_model.xfer({w, crc8(w) ^ {7'h00, bad}}, 32);
      else
         u_spi_host_model.xfer({8'hA5, w}, 32);
   endtask
   task automatic rdreg(input logic [6:0] a);
      send(1'b1, a, 16'h0000);
      send(1'b0, 7'h00, 16'h0000);
      d = u_spi_host_model.rd[23:8];
   endtask
   task automatic ld;
      @(posedge clock) load_latch_strobe_n <= 1'b0;
      repeat (8) @(posedge clock);
      load_latch_strobe_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      reset = 1'b1;
      reset_pin_n = 1'b1;
      output_wipe_input = 1'b0;
      load_latch_strobe_n = 1'b1;
      chk = 1'b0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      repeat (10) @(posedge clock);
      `check_eq("oe_n", 1'b1, serial_out_oe_n)
      send(0, 7'h02, 16'h1E12);
      `check_eq("ref", 1'b1, ref_enable)
      u_spi_host_model.xfer({1'b0, 7'h02, 16'h0000}, 23);
      `check_eq("short", 1'b1, ref_enable)
      rdreg(7'h02);
      `check_eq("rcfg", 16'h1E12, d)
      // channels a and b, a wipes to midscale
      send(0, 7'h03, 16'h0260);
      send(0, 7'h05, 16'h1234);
      ld();
      `check_eq("code_b", 16'h1234, channel_code[1])
      `check_eq("code_c", 16'h0000, channel_code[2])
      output_wipe_input <= 1'b1;
      repeat (8) @(posedge clock);
      `check_eq("wipe_a", dac_core_pkg::MIDSCALE, channel_code[0])
      `check_eq("wipe_b", dac_core_pkg::ZEROSCALE, channel_code[1])
      send(0, 7'h05, 16'h00FF);
      ld();
      `check_eq("wipe_ld", dac_core_pkg::MIDSCALE, channel_code[0])
      output_wipe_input <= 1'b0;
      ld();
      `check_eq("wiped", dac_core_pkg::MIDSCALE, channel_code[0])
      rdreg(7'h05);
      `check_eq("kept", 16'h00FF, d)
      send(0, 7'h09, 16'h0000);
      send(0, 7'h0A, 16'hFFF0);
      send(0, 7'h05, 16'h1234);
      ld();
      `check_eq("no_trim", 16'h1234, channel_code[0])
      send(0, 7'h08, 16'h0001);
      ld();
      `check_eq("trim", 16'h090A, channel_code[1])
      send(0, 7'h0A, 16'h8000);
      ld();
      `check_eq("trim_sat", 16'h0000, channel_code[0])
      send(0, 7'h03, 16'h0268);
      chk = 1'b1;
      send(0, 7'h05, 16'h5555, 1'b1);
      `check_eq("alarm", 1'b0, alarm_oe_n ? 1'b1 : alarm_out)
      rdreg(7'h05);
      `check_eq("blocked", 16'h1234, d)
      `check_eq("rd_crc", crc8(u_spi_host_model.rd[31:8]), u_spi_host_model.rd[7:0])
      rdreg(7'h0B);
      `check_eq("cre", 16'h1020, d & 16'h1020)
      send(0, 7'h03, 16'h0260);
      chk = 1'b0;
      `check_eq("cre_off", 1'b1, alarm_oe_n)
      send(0, 7'h10, 16'h0001);
      `check_eq("kick", 1, kicks)
      rdreg(7'h11);
      `check_eq("id", 16'h0003, d)
      rdreg(7'h0F);
      `check_eq("rsvd", 16'h0000, d)
      send(0, 7'h01, 16'h0001);
      `check_eq("srst_ref", 1'b0, ref_enable)
      `check_eq("srst_poc", 1'b1, power_off_condition)
      rdreg(7'h01);
      `check_eq("srst_bit", 16'h0000, d)
      // power-off condition set here so that the pin reset has something to keep
      send(0, 7'h02, 16'h0012);
      @(posedge clock) reset_pin_n <= 1'b0;
      repeat (10) @(posedge clock);
      send(0, 7'h02, 16'h0010);
      `check_eq("hw_ref", 1'b0, ref_enable)
      `check_eq("hw_oe", 1'b1, serial_out_oe_n)
      `check_eq("hw_poc", 1'b1, power_off_condition)
      @(posedge clock) reset_pin_n <= 1'b1;
      repeat (10) @(posedge clock);
      send(0, 7'h02, 16'h0010);
      `check_eq("resume", 1'b1, ref_enable)
      final_report();
   end
   initial
   begin
      #400000;
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
